//--- bench/ckrt_assertions.sv
// Concurrent checks on the clock routing controller ports
`timescale 1ns/1ps
module ckrt_assertions
  import ckrt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] input_clock_present,
  input wire logic [4:0] crystal_load_capacitance,
  input wire logic recal_start,
  input wire logic outputs_enable,
  input wire logic [6*NUM_OUT-1:0] output_divider
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_recal_outs_off: assert property (recal_start |=> !outputs_enable)
    else $error("outputs on during recalibration");
  a_start_clock: assert property ($rose(outputs_enable) |-> $past(|input_clock_present))
    else $error("outputs started without input clock");
  a_cap_range: assert property (crystal_load_capacitance >= CAP_MIN && crystal_load_capacitance <= CAP_MAX)
    else $error("load capacitance code out of range");
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_div
    a_div_nonzero: assert property (output_divider[6*i+:6] != 6'h00)
      else $error("output divider is zero");
  end
  a_recal_pulse: assert property (recal_start |=> !recal_start)
    else $error("recalibration start longer than one cycle");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  c_recal: cover property (recal_start);
  c_out_on: cover property ($rose(outputs_enable));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

//--- bench/ckrt_ref_model.sv
// Reference sources and oscillator calibrator facing the controller
`timescale 1ns/1ps
module ckrt_ref_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [2:0] clk_mask,
  input wire logic slow,
  input wire logic [2:0] input_enable,
  input wire logic recal_start,
  output logic [2:0] input_clock_present,
  output logic recal_done
);
  int cnt;
  // A disabled receiver reports no clock even when a source is wired up
  assign input_clock_present = clk_mask & input_enable;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      recal_done <= 1'b0;
    end else begin
      recal_done <= (cnt == 1);
      // The slow case outlasts the controller's bound so its timeout path runs
      if (recal_start) cnt <= slow ? 12 : 4;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule

//--- bench/tb.sv
// Self-checking bench for the clock routing controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
  import ckrt_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} ckrt_row_s;
  logic core_clk = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_input, input_format;
  logic [1:0] input_source_selector_pins = 2'h0;
  logic [2:0] input_clock_present, input_enable, clk_mask = 3'h0;
  logic recal_done, recal_start, outputs_enable, crystal_load_enable;
  logic [4:0] crystal_load_capacitance;
  logic [3*NUM_ROUTE-1:0] route_source;
  logic [6*NUM_OUT-1:0] output_divider;
  logic [NUM_OUT-1:0] output_single_ended, output_term_85;
  logic [2*NUM_OUT-1:0] output_format;
  int errors = 0, samples_checked = 0;
  ckrt_row_s rows [14] = '{
    '{8'h00, 32'h8, 32'h8, RESP_OKAY},
    '{8'h04, 32'h7, 32'h7, RESP_OKAY}, '{8'h04, 32'hF, 32'hF, RESP_OKAY},
    '{8'h04, 32'h17, 32'h17, RESP_OKAY}, '{8'h04, 32'h1B, 32'h1B, RESP_OKAY},
    '{8'h08, 32'h3F, 32'h3E, RESP_OKAY}, '{8'h08, 32'h21, 32'h22, RESP_OKAY},
    '{8'h08, 32'hA, 32'hA, RESP_OKAY}, '{8'h20, 32'h7, 32'h7, RESP_OKAY},
    '{8'h34, 32'h2, 32'h2, RESP_OKAY}, '{8'h40, 32'h0, 32'h1, RESP_OKAY},
    '{8'h6C, 32'hF3F, 32'hF3F, RESP_OKAY}, '{8'hFC, 32'h1, 32'h0, RESP_SLVERR},
    '{8'h10, 32'hFF, 32'h0, RESP_OKAY}};
  ckrt_top #(.RECAL_CYCLES(10)) u_ckrt_top (.*);
  ckrt_ref_model u_ckrt_ref_model (.*);
  always #25 core_clk = ~core_clk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic sel(input logic [31:0] d, input logic [1:0] p);
    logic [1:0] r;
    input_source_selector_pins <= p;
    wr(REG_INSEL, d, r);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK("div_rst", DIV_RESET, output_divider[5:0])
    `CHK("fmt_rst", FMT_LVCMOS, input_format)
    `CHK("in_en_rst", 3'h7, input_enable)
    repeat (20) @(posedge core_clk);
    `CHK("no_clk", 1'b0, outputs_enable)
    clk_mask <= 3'h7;
    for (int i = 0; i < 40 && outputs_enable !== 1'b1; i++) @(posedge core_clk);
    `CHK("start", 1'b1, outputs_enable)
    $display("test start done");
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d, r);
      `CHK("wresp", rows[k].r, r)
      rd(rows[k].a, q, r);
      `CHK("rresp", rows[k].r, r)
      if (r === RESP_OKAY && rows[k].a !== REG_STATUS) `CHK("rdata", rows[k].q, q)
    end
    `CHK("route5", SRC_REF, route_source[17:15])
    `CHK("route0", SRC_INT4, route_source[2:0])
    `CHK("div11", 6'h3F, output_divider[71:66])
    `CHK("oc11", 4'hF, {output_term_85[11], output_format[23:22], output_single_ended[11]})
    `CHK("cap", 6'h0A, {crystal_load_enable, crystal_load_capacitance})
    `CHK("in_cfg", 5'h1B, {input_format, input_enable})
    $display("test table done");
    wr(REG_INCFG, 32'h1F, r);
    sel(32'h1, 2'h2);
    `CHK("reg_sel", SEL_CLK_A, active_input)
    `CHK("no_recal", 1'b1, outputs_enable)
    sel(32'h5, 2'h2);
    `CHK("pin_sel", SEL_CLK_B, active_input)
    sel(32'h6, 2'h0);
    `CHK("pin_only", SEL_XTAL, active_input)
    rd(REG_STATUS, q, r);
    `CHK("stat_act", SEL_XTAL, q[1:0])
    sel(32'h2, 2'h1);
    `CHK("reg_only", SEL_CLK_B, active_input)
    $display("test select done");
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      wr(REG_CTRL, 32'h1, r);
      repeat (2) @(posedge core_clk);
      `CHK("recal_off", 1'b0, outputs_enable)
      for (int j = 0; j < 40 && outputs_enable !== 1'b1; j++) @(posedge core_clk);
      `CHK("resume", 1'b1, outputs_enable)
    end
    $display("test recal done");
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("rst_outs", 1'b0, outputs_enable)
    `CHK("rst_div", DIV_RESET, output_divider[71:66])
    `CHK("rst_cap", {1'b1, CAP_MIN}, {crystal_load_enable, crystal_load_capacitance})
    rstn <= 1'b1;
    for (int j = 0; j < 40 && outputs_enable !== 1'b1; j++) @(posedge core_clk);
    `CHK("rst_start", 1'b1, outputs_enable)
    $display("test reset done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end
endmodule
bind ckrt_top ckrt_assertions u_ckrt_assertions (.*);

//--- hw/ckrt_top.sv
// Clock input selection, crosspoint routing and output configuration controller
// Overview of operation
// - Reference input chosen by register or pins
// - Config bit picks pin or register selection
// - Outputs start only once selected input has clock
// - Outputs resume once recalibration completes
// - Small-offset switch: no recalibration, PLL follows
// - Switching not hitless, no phase build-out
// - Route sources: two synths, reference, five dividers
// - Eight-output: four single, two shared banks
// - Twelve-output: two single, four shared banks
// - Reference source passes input clock straight through
// - Per-output post-divider 1..63, default 1
// - Each output differential or dual CMOS
// - Output format set over serial interface
// - Input format LVPECL, LVDS, HCSL or LVCMOS
// - Unused inputs disabled by register
// - Crystal load capacitance selectable or disabled
// - HCSL termination 100 or 85 ohm
`timescale 1ns/1ps
module ckrt_top
  import ckrt_pkg::*;
#(
  parameter int unsigned RECAL_CYCLES = RECAL_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] input_source_selector_pins,
  input wire logic [2:0] input_clock_present,
  input wire logic recal_done,
  output logic [1:0] active_input,
  output logic [2:0] input_enable,
  output logic [1:0] input_format,
  output logic [4:0] crystal_load_capacitance,
  output logic crystal_load_enable,
  output logic recal_start,
  output logic outputs_enable,
  output logic [3*NUM_ROUTE-1:0] route_source,
  output logic [6*NUM_OUT-1:0] output_divider,
  output logic [NUM_OUT-1:0] output_single_ended,
  output logic [2*NUM_OUT-1:0] output_format,
  output logic [NUM_OUT-1:0] output_term_85
);

  typedef struct packed {
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic pin_mode;
    logic [1:0] reg_sel;
    logic [2:0] in_en;
    logic [1:0] in_fmt;
    logic [4:0] cap;
    logic cap_en;
    logic variant12;
    logic [3*NUM_ROUTE-1:0] route;
    logic [12*NUM_OUT-1:0] ocfg;
    logic [1:0] act_sel;
    ckrt_state_e state;
    logic [31:0] cnt;
    logic recal_req;
    logic recal_pulse;
    logic outs_on;
  } ckrt_state_s;

  logic rst_meta;
  logic rst_sync;
  ckrt_state_s st;
  ckrt_state_s next_st;
  logic [1:0] sel_now;
  logic sel_present;

  // Release is synchronised so every state flop leaves reset on the same edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Chosen selection source masks the other completely
  assign sel_now = st.pin_mode ? input_source_selector_pins : st.reg_sel;
  assign sel_present = (sel_now <= SEL_CLK_B) && input_clock_present[sel_now] && st.in_en[sel_now];

  function automatic logic [5:0] clamp_div(input logic [5:0] d);
    clamp_div = (d < DIV_MIN) ? DIV_MIN : d;
  endfunction

  // Out-of-range load codes are pinned to the nearest legal one
  function automatic logic [4:0] clamp_cap(input logic [4:0] c);
    clamp_cap = (c < CAP_MIN) ? CAP_MIN : ((c > CAP_MAX) ? CAP_MAX : c);
  endfunction

  // Byte strobes pick which bytes of the old word are replaced
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    wmerge = r;
  endfunction

  always_comb begin
    logic [31:0] rd;
    logic ok;
    logic [31:0] m;
    logic [7:0] a;
    logic req_set;
    rd = 32'h0000_0000;
    ok = 1'b1;
    m = 32'h0000_0000;
    a = 8'h00;
    req_set = 1'b0;
    next_st = st;
    next_st.recal_pulse = 1'b0;

    if (s_axi_awvalid && !st.aw_hold) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_hold) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Write once both halves are held and the previous response is gone
    if (st.aw_hold && st.w_hold && !st.bvalid) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      a = st.aw_addr;
      // Variant bit only tags the part; every route slot is used by both variants
      if (a == REG_INSEL) begin
        m = wmerge({28'h0, st.variant12, st.pin_mode, st.reg_sel}, st.w_data, st.w_strb);
        next_st.reg_sel = m[1:0];
        next_st.pin_mode = m[2];
        next_st.variant12 = m[3];
      end else if (a == REG_INCFG) begin
        m = wmerge({27'h0, st.in_fmt, st.in_en}, st.w_data, st.w_strb);
        next_st.in_en = m[2:0];
        next_st.in_fmt = m[4:3];
      end else if (a == REG_XTAL) begin
        m = wmerge({26'h0, st.cap_en, st.cap}, st.w_data, st.w_strb);
        next_st.cap = clamp_cap(m[4:0]);
        next_st.cap_en = m[5];
      end else if (a == REG_CTRL) begin
        // Manual recalibration is the host's call after a large offset switch
        if (st.w_strb[0] && st.w_data[0]) begin
          req_set = 1'b1;
        end
      end else if (a >= REG_ROUTE && a < REG_ROUTE + 8'(4 * NUM_ROUTE)) begin
        for (int i = 0; i < NUM_ROUTE; i++) begin
          if (a == REG_ROUTE + 8'(4 * i) && st.w_strb[0]) begin
            next_st.route[3*i +: 3] = st.w_data[2:0];
          end
        end
      end else if (a >= REG_OUTCFG && a < REG_OUTCFG + 8'(4 * NUM_OUT)) begin
        for (int i = 0; i < NUM_OUT; i++) begin
          if (a == REG_OUTCFG + 8'(4 * i)) begin
            m = wmerge({20'h0, st.ocfg[12*i +: 12]}, st.w_data, st.w_strb);
            m[OC_DIV_LSB +: OC_DIV_W] = clamp_div(m[OC_DIV_LSB +: OC_DIV_W]);
            next_st.ocfg[12*i +: 12] = m[11:0];
          end
        end
      end else if (a != REG_STATUS) begin
        ok = 1'b0;
      end
      next_st.bresp = ok ? RESP_OKAY : RESP_SLVERR;
    end

    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Reads answer on the next edge; a bad write in the same cycle must not taint it
    if (s_axi_arvalid && !st.rvalid) begin
      ok = 1'b1;
      a = s_axi_araddr;
      if (a == REG_INSEL) begin
        rd = {28'h0, st.variant12, st.pin_mode, st.reg_sel};
      end else if (a == REG_INCFG) begin
        rd = {27'h0, st.in_fmt, st.in_en};
      end else if (a == REG_XTAL) begin
        rd = {26'h0, st.cap_en, st.cap};
      end else if (a == REG_CTRL) begin
        rd = {31'h0, st.recal_req};
      end else if (a == REG_STATUS) begin
        rd = {24'h0, input_clock_present, st.state, st.outs_on, st.act_sel};
      end else if (a >= REG_ROUTE && a < REG_ROUTE + 8'(4 * NUM_ROUTE)) begin
        for (int i = 0; i < NUM_ROUTE; i++) begin
          if (a == REG_ROUTE + 8'(4 * i)) begin
            rd = {29'h0, st.route[3*i +: 3]};
          end
        end
      end else if (a >= REG_OUTCFG && a < REG_OUTCFG + 8'(4 * NUM_OUT)) begin
        for (int i = 0; i < NUM_OUT; i++) begin
          if (a == REG_OUTCFG + 8'(4 * i)) begin
            rd = {20'h0, st.ocfg[12*i +: 12]};
          end
        end
      end else begin
        ok = 1'b0;
      end
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Input switch follows selection directly; no phase build-out, the PLL absorbs it
    next_st.act_sel = sel_now;

    case (st.state)
      ST_WAIT_REF: begin
        next_st.outs_on = 1'b0;
        if (sel_present) begin
          next_st.state = ST_RUN;
          next_st.outs_on = 1'b1;
        end
      end
      ST_RUN: begin
        // No offset detection here: only a host request recalibrates
        if (st.recal_req) begin
          next_st.recal_req = 1'b0;
          next_st.recal_pulse = 1'b1;
          next_st.outs_on = 1'b0;
          next_st.cnt = 32'h0000_0000;
          next_st.state = ST_RECAL;
        end
      end
      ST_RECAL: begin
        next_st.outs_on = 1'b0;
        // Calibrator may never answer; the count bounds the wait
        if (recal_done || st.cnt >= RECAL_CYCLES - 1) begin
          next_st.state = sel_present ? ST_RUN : ST_WAIT_REF;
          next_st.outs_on = sel_present;
        end else begin
          next_st.cnt = st.cnt + 32'h0000_0001;
        end
      end
      default: begin
        next_st.state = ST_WAIT_REF;
      end
    endcase

    // A request written while the previous one is taken still counts: set wins
    if (req_set) begin
      next_st.recal_req = 1'b1;
    end
    // Readies kept as flops so the bus outputs carry no logic
    next_st.aw_rdy = !next_st.aw_hold;
    next_st.w_rdy = !next_st.w_hold;
    next_st.ar_rdy = !next_st.rvalid;
  end

  // Reset loads the power-up defaults; readies come up high
  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= '0;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
      st.in_en <= 3'h7;
      st.in_fmt <= FMT_LVCMOS;
      st.cap <= CAP_MIN;
      st.cap_en <= 1'b1;
      st.state <= ST_WAIT_REF;
      for (int i = 0; i < NUM_ROUTE; i++) begin
        st.route[3*i +: 3] <= SRC_FRAC0;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        st.ocfg[12*i + OC_DIV_LSB +: OC_DIV_W] <= DIV_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready = st.w_rdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign active_input = st.act_sel;
  assign input_enable = st.in_en;
  assign input_format = st.in_fmt;
  assign crystal_load_capacitance = st.cap;
  assign crystal_load_enable = st.cap_en;
  assign recal_start = st.recal_pulse;
  assign outputs_enable = st.outs_on;

  // Route slot i: 0..3 single outputs then two banks (8-out), or 0..1 single then four
  // banks (12-out), so all six slots serve both; SRC_REF fans the input clock out
  assign route_source = st.route;

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      output_divider[6*i +: 6] = st.ocfg[12*i + OC_DIV_LSB +: OC_DIV_W];
      output_single_ended[i] = st.ocfg[12*i + OC_SE_BIT];
      output_format[2*i +: 2] = st.ocfg[12*i + OC_FMT_LSB +: 2];
      output_term_85[i] = st.ocfg[12*i + OC_TERM85_BIT];
    end
  end

endmodule

//--- inc/ckrt_pkg.sv
// Package with register map, field layouts and enumerations of the clock routing controller
package ckrt_pkg;

  localparam int unsigned NUM_OUT = 12;
  localparam int unsigned NUM_ROUTE = 6;

  // Register byte offsets
  localparam logic [7:0] REG_INSEL = 8'h00;
  localparam logic [7:0] REG_INCFG = 8'h04;
  localparam logic [7:0] REG_XTAL = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ROUTE = 8'h20;
  localparam logic [7:0] REG_OUTCFG = 8'h40;

  // Input selection encodings
  localparam logic [1:0] SEL_XTAL = 2'h0;
  localparam logic [1:0] SEL_CLK_A = 2'h1;
  localparam logic [1:0] SEL_CLK_B = 2'h2;

  // Crosspoint mux sources
  localparam logic [2:0] SRC_FRAC0 = 3'h0;
  localparam logic [2:0] SRC_FRAC1 = 3'h1;
  localparam logic [2:0] SRC_REF = 3'h2;
  localparam logic [2:0] SRC_INT0 = 3'h3;
  localparam logic [2:0] SRC_INT4 = 3'h7;

  // Input formats
  localparam logic [1:0] FMT_LVPECL = 2'h0;
  localparam logic [1:0] FMT_LVDS = 2'h1;
  localparam logic [1:0] FMT_HCSL = 2'h2;
  localparam logic [1:0] FMT_LVCMOS = 2'h3;

  // Output configuration fields
  localparam int unsigned OC_DIV_LSB = 0;
  localparam int unsigned OC_DIV_W = 6;
  localparam int unsigned OC_SE_BIT = 8;
  localparam int unsigned OC_FMT_LSB = 9;
  localparam int unsigned OC_TERM85_BIT = 11;
  localparam logic [5:0] DIV_MIN = 6'h01;
  localparam logic [5:0] DIV_RESET = 6'h01;

  // Crystal load capacitance range, in pF codes
  localparam logic [4:0] CAP_MIN = 5'h02;
  localparam logic [4:0] CAP_MAX = 5'h1E;

  // Recalibration time
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RECAL_US = 100;
  localparam int unsigned RECAL_CYC = (RECAL_US * (CLK_HZ / 1_000_000));

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_WAIT_REF, ST_RUN, ST_RECAL} ckrt_state_e;

endpackage
